// file: pkg/reload_timer_pkg.sv
// constants and types for the dual 16-bit reload timer
// assumes a 32-bit apb master and one machine clock
package reload_timer_pkg;
	// channels and widths
	localparam int NUM_CH = 2;
	localparam int CNT_W = 16;
	localparam int PRESC_W = 5;
	// apb byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_RELOAD = 8'h04;
	localparam logic [7:0] OFF_COUNT = 8'h08;
	localparam logic [7:0] CH_STRIDE = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	localparam logic [7:0] OFF_MASK = 8'h24;
	// control field positions
	localparam int SW_TRIG_BIT = 6;
	localparam int RUN_BIT = 7;
	// count clock select codes; 11 is event count
	localparam logic [1:0] SEL_INT0 = 2'h0;
	localparam logic [1:0] SEL_INT1 = 2'h1;
	localparam logic [1:0] SEL_INT2 = 2'h2;
	localparam logic [1:0] SEL_EVENT = 2'h3;
	// internal periods of 2, 8 and 32 machine clocks
	localparam logic [PRESC_W-1:0] DIV_MASK0 = 5'h01;
	localparam logic [PRESC_W-1:0] DIV_MASK1 = 5'h07;
	localparam logic [PRESC_W-1:0] DIV_MASK2 = 5'h1f;
	// reset values
	localparam logic [CNT_W-1:0] RELOAD_RST = 16'hffff;
	localparam logic [CNT_W-1:0] COUNT_RST = 16'hffff;

	typedef struct packed {
		logic io_en;
		logic trig_ext;
		logic reload_mode;
		logic count_en;
		logic count_clock_select_hi;
		logic count_clock_select_lo;
	} ctrl_type;

	localparam ctrl_type CTRL_RST = 6'h00;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN = 1'b1
	} state_type;
endpackage

// file: hw/reload_timer_pair.sv
// two 16-bit down counters with reload, apb registers and one interrupt
// assumes apb on core_clk; trigger and event pins are asynchronous
//
// How it works
// - count clock is one of three internal rates or the event pin.
// - control bit adds the external trigger pin in the three internal modes; the software trigger works whenever count_en is already set.
// - a trigger edge loads the reload value and starts counting.
// - underflow sets a sticky status bit that can raise the interrupt.
// - one-shot mode stops counting at underflow.
// - reload mode copies the reload value on underflow and keeps counting.
// - select codes 00, 01, 10 give three different internal periods.
// - internal mode decrements once per selected internal period.
// - two independent channels, each with counter, reload and control.
// - underflow also requests the extended io service when enabled.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
module reload_timer_pair
(
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins
	input wire logic [1:0] ext_trig_in,
	input wire logic [1:0] ext_event_in,
	// requests
	output logic irq,
	output logic [1:0] io_service_req
);
	localparam int N = reload_timer_pkg::NUM_CH;
	localparam int W = reload_timer_pkg::CNT_W;

	reload_timer_pkg::ctrl_type ctrl_reg [N];
	reload_timer_pkg::ctrl_type ctrl_next [N];
	reload_timer_pkg::state_type state_reg [N];
	reload_timer_pkg::state_type state_next [N];
	logic [W-1:0] reload_reg [N];
	logic [W-1:0] reload_next [N];
	logic [W-1:0] count_reg [N];
	logic [W-1:0] count_next [N];
	logic [N-1:0] tick_w;
	logic [N-1:0] trig_w;
	logic [N-1:0] uf_w;
	logic [N-1:0] sw_trig_w;
	logic [N-1:0] io_en_w;

	logic [N-1:0] trig_s1_reg, trig_s2_reg, trig_d_reg;
	logic [N-1:0] ev_s1_reg, ev_s2_reg, ev_d_reg;
	logic [N-1:0] trig_edge, ev_edge;
	logic [reload_timer_pkg::PRESC_W-1:0] presc_reg;

	logic [N-1:0] status_reg, status_next;
	logic [N-1:0] mask_reg, mask_next;
	logic irq_reg, irq_next;
	logic [N-1:0] io_req_reg, io_req_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic wr_en;
	logic hit;

	// one clock domain, so one default clocking and reset for every check
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// pins pass two sync flops; edge detect reads the second and a delayed copy of it
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			trig_s1_reg <= 2'h0;
			trig_s2_reg <= 2'h0;
			trig_d_reg <= 2'h0;
			ev_s1_reg <= 2'h0;
			ev_s2_reg <= 2'h0;
			ev_d_reg <= 2'h0;
			presc_reg <= 5'h00;
		end
		else if (clk_en)
		begin
			trig_s1_reg <= ext_trig_in;
			trig_s2_reg <= trig_s1_reg;
			trig_d_reg <= trig_s2_reg;
			ev_s1_reg <= ext_event_in;
			ev_s2_reg <= ev_s1_reg;
			ev_d_reg <= ev_s2_reg;
			presc_reg <= presc_reg + 5'h01;
		end
	end

	// rising edges only
	assign trig_edge = trig_s2_reg & ~trig_d_reg;
	assign ev_edge = ev_s2_reg & ~ev_d_reg;
	// write takes effect only at the access edge with pready high
	assign wr_en = psel & penable & pwrite & pready_reg;

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_ch
			localparam logic [7:0] A_CTRL = 8'(reload_timer_pkg::OFF_CTRL + i * reload_timer_pkg::CH_STRIDE);
			localparam logic [7:0] A_RELOAD = 8'(reload_timer_pkg::OFF_RELOAD + i * reload_timer_pkg::CH_STRIDE);
			logic [1:0] sel;

			always_comb
			begin
				sel = {ctrl_reg[i].count_clock_select_hi, ctrl_reg[i].count_clock_select_lo};
				unique case (sel)
					reload_timer_pkg::SEL_INT0: tick_w[i] = (presc_reg & reload_timer_pkg::DIV_MASK0) == 5'h00;
					reload_timer_pkg::SEL_INT1: tick_w[i] = (presc_reg & reload_timer_pkg::DIV_MASK1) == 5'h00;
					reload_timer_pkg::SEL_INT2: tick_w[i] = (presc_reg & reload_timer_pkg::DIV_MASK2) == 5'h00;
					reload_timer_pkg::SEL_EVENT: tick_w[i] = ev_edge[i];
				endcase
				sw_trig_w[i] = wr_en && paddr == A_CTRL && pwdata[reload_timer_pkg::SW_TRIG_BIT];
				// count_en must already be set: a write that enables and triggers at once does not start
				// trigger source; event mode ignores the pin
				trig_w[i] = ctrl_reg[i].count_en && (sw_trig_w[i] || (ctrl_reg[i].trig_ext && trig_edge[i]
					&& sel != reload_timer_pkg::SEL_EVENT));
				uf_w[i] = state_reg[i] == reload_timer_pkg::ST_RUN && ctrl_reg[i].count_en && !trig_w[i]
					&& tick_w[i] && count_reg[i] == '0;
				io_en_w[i] = ctrl_reg[i].io_en;

				ctrl_next[i] = ctrl_reg[i];
				reload_next[i] = reload_reg[i];
				state_next[i] = state_reg[i];
				count_next[i] = count_reg[i];
				if (wr_en && paddr == A_CTRL)
					ctrl_next[i] = pwdata[5:0];
				if (wr_en && paddr == A_RELOAD)
					reload_next[i] = pwdata[W-1:0];
				// a restart wins over a tick in the same cycle
				if (!ctrl_reg[i].count_en)
					state_next[i] = reload_timer_pkg::ST_IDLE;
				else if (trig_w[i])
				begin
					state_next[i] = reload_timer_pkg::ST_RUN;
					count_next[i] = reload_reg[i];
				end
				else if (uf_w[i] && ctrl_reg[i].reload_mode)
					count_next[i] = reload_reg[i];
				else if (uf_w[i])
				begin
					state_next[i] = reload_timer_pkg::ST_IDLE;
					count_next[i] = count_reg[i] - 16'h0001;
				end
				else if (state_reg[i] == reload_timer_pkg::ST_RUN && tick_w[i])
					count_next[i] = count_reg[i] - 16'h0001;
			end

			always_ff @(posedge core_clk or negedge resetn)
			begin
				if (!resetn)
				begin
					ctrl_reg[i] <= reload_timer_pkg::CTRL_RST;
					reload_reg[i] <= reload_timer_pkg::RELOAD_RST;
					count_reg[i] <= reload_timer_pkg::COUNT_RST;
					state_reg[i] <= reload_timer_pkg::ST_IDLE;
				end
				else if (clk_en)
				begin
					ctrl_reg[i] <= ctrl_next[i];
					reload_reg[i] <= reload_next[i];
					count_reg[i] <= count_next[i];
					state_reg[i] <= state_next[i];
				end
			end

			start_load_a: assert property (trig_w[i] && clk_en |=>
				state_reg[i] == reload_timer_pkg::ST_RUN && count_reg[i] == $past(reload_reg[i]))
				else $error("trigger did not load and start");
			oneshot_stop_a: assert property (uf_w[i] && !ctrl_reg[i].reload_mode && clk_en |=>
				state_reg[i] == reload_timer_pkg::ST_IDLE && count_reg[i] == 16'hffff)
				else $error("one-shot did not stop");
			reload_copy_a: assert property (uf_w[i] && ctrl_reg[i].reload_mode && clk_en |=>
				state_reg[i] == reload_timer_pkg::ST_RUN && count_reg[i] == $past(reload_reg[i]))
				else $error("reload mode did not reload");
			count_down_a: assert property (state_reg[i] == reload_timer_pkg::ST_RUN && ctrl_reg[i].count_en
				&& tick_w[i] && !trig_w[i] && count_reg[i] != '0 && clk_en |=> count_reg[i] == $past(count_reg[i]) - 16'h0001)
				else $error("count did not step down");
			hold_count_a: assert property (!tick_w[i] && !trig_w[i] && clk_en |=> $stable(count_reg[i]))
				else $error("count moved without a tick");
			slow_rate_a: assert property (sel == reload_timer_pkg::SEL_INT2 && tick_w[i] && clk_en
				|=> (!tick_w[i] || sel != reload_timer_pkg::SEL_INT2) [*8])
				else $error("slowest rate ticks too often");
			event_tick_a: assert property (sel == reload_timer_pkg::SEL_EVENT |-> tick_w[i] == ev_edge[i])
				else $error("event mode tick not from event edge");
			event_trig_a: assert property (sel == reload_timer_pkg::SEL_EVENT && !sw_trig_w[i] |-> !trig_w[i])
				else $error("event mode took the pin trigger");
			io_request_a: assert property (uf_w[i] && clk_en |=> io_service_req[i] == $past(io_en_w[i]))
				else $error("io service request wrong");
			pin_ignored_a: assert property (!ctrl_reg[i].trig_ext && !sw_trig_w[i]
				|-> !trig_w[i])
				else $error("pin trigger taken while not selected");
			ctrl_write_a: assert property (wr_en && paddr == A_CTRL && clk_en
				|=> ctrl_reg[i] == $past(pwdata[5:0]))
				else $error("control value not stored");
			trig_edge_a: assert property (trig_w[i] && !sw_trig_w[i]
				|-> trig_edge[i])
				else $error("start without a pin edge");
			stop_clear_a: assert property (!ctrl_reg[i].count_en && clk_en
				|=> state_reg[i] == reload_timer_pkg::ST_IDLE)
				else $error("timer runs without enable");
			flag_set_a: assert property (uf_w[i] && clk_en
				|=> status_reg[i])
				else $error("underflow flag not set");
			stay_stopped_a: assert property (state_reg[i] == reload_timer_pkg::ST_IDLE && clk_en
				&& !trig_w[i] |=> state_reg[i] == reload_timer_pkg::ST_IDLE && $stable(count_reg[i]))
				else $error("stopped timer moved");
			reload_write_a: assert property (wr_en && paddr == A_RELOAD && clk_en
				|=> reload_reg[i] == $past(pwdata[W-1:0]))
				else $error("reload value not stored");
			fast_rate_a: assert property (sel == reload_timer_pkg::SEL_INT0 && tick_w[i] && clk_en
				|=> !tick_w[i] || sel == reload_timer_pkg::SEL_EVENT)
				else $error("fastest rate ticks twice in a row");
			mid_rate_a: assert property (sel == reload_timer_pkg::SEL_INT1 && tick_w[i] && clk_en
				|=> (!tick_w[i] || sel != reload_timer_pkg::SEL_INT1) [*7])
				else $error("middle rate ticks too often");
			enable_freeze_a: assert property (!clk_en
				|=> $stable(count_reg[i]) && $stable(state_reg[i]))
				else $error("state moved while clock enable low");
			io_quiet_a: assert property (!uf_w[i] && clk_en
				|=> !io_service_req[i])
				else $error("service request without underflow");
			event_count_a: assert property (sel == reload_timer_pkg::SEL_EVENT && ev_edge[i] && clk_en
				&& state_reg[i] == reload_timer_pkg::ST_RUN && ctrl_reg[i].count_en
				&& !trig_w[i] && count_reg[i] != '0 |=> count_reg[i] == $past(count_reg[i]) - 16'h0001)
				else $error("event edge did not count down");
			reload_cov: cover property (uf_w[i] && ctrl_reg[i].reload_mode);
			oneshot_cov: cover property (uf_w[i] && !ctrl_reg[i].reload_mode);
			event_cov: cover property (sel == reload_timer_pkg::SEL_EVENT && uf_w[i]);
			pin_start_cov: cover property (trig_w[i] && !sw_trig_w[i]);
		end
	endgenerate

	// sticky underflow; set wins over write-one-clear
	always_comb
	begin
		status_next = status_reg;
		mask_next = mask_reg;
		if (wr_en && paddr == reload_timer_pkg::OFF_STATUS)
			status_next = status_reg & ~pwdata[N-1:0];
		if (wr_en && paddr == reload_timer_pkg::OFF_MASK)
			mask_next = pwdata[N-1:0];
		status_next = status_next | uf_w;
		irq_next = |(status_next & mask_next);
		io_req_next = uf_w & io_en_w;
	end

	// apb answer one cycle after setup; unmapped reads zero with pslverr
	always_comb
	begin
		hit = 1'b1;
		prdata_next = 32'h0000_0000;
		unique case (paddr)
			reload_timer_pkg::OFF_CTRL:
				prdata_next = {24'h0, state_reg[0] == reload_timer_pkg::ST_RUN, 1'b0, ctrl_reg[0]};
			reload_timer_pkg::OFF_RELOAD: prdata_next = {16'h0, reload_reg[0]};
			reload_timer_pkg::OFF_COUNT: prdata_next = {16'h0, count_reg[0]};
			8'(reload_timer_pkg::OFF_CTRL + reload_timer_pkg::CH_STRIDE):
				prdata_next = {24'h0, state_reg[1] == reload_timer_pkg::ST_RUN, 1'b0, ctrl_reg[1]};
			8'(reload_timer_pkg::OFF_RELOAD + reload_timer_pkg::CH_STRIDE): prdata_next = {16'h0, reload_reg[1]};
			8'(reload_timer_pkg::OFF_COUNT + reload_timer_pkg::CH_STRIDE): prdata_next = {16'h0, count_reg[1]};
			reload_timer_pkg::OFF_STATUS: prdata_next = {30'h0, status_reg};
			reload_timer_pkg::OFF_MASK: prdata_next = {30'h0, mask_reg};
			default: hit = 1'b0;
		endcase
		pready_next = psel & ~penable;
		pslverr_next = psel & ~penable & ~hit;
		if (!(psel && !penable))
			prdata_next = prdata_reg;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			status_reg <= 2'h0;
			mask_reg <= 2'h0;
			irq_reg <= 1'b0;
			io_req_reg <= 2'h0;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			status_reg <= status_next;
			mask_reg <= mask_next;
			irq_reg <= irq_next;
			io_req_reg <= io_req_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;
	assign io_service_req = io_req_reg;

	irq_level_a: assert property (irq == |(status_reg & mask_reg))
		else $error("irq does not match masked status");
	sticky_set_a: assert property (uf_w[0] && clk_en |=> status_reg[0])
		else $error("underflow lost");
	apb_ready_a: assert property (psel && !penable && clk_en |=> pready ##1 !pready)
		else $error("apb answer not one cycle");
	// bus side register checks
	w1c_clear_a: assert property (wr_en && paddr == reload_timer_pkg::OFF_STATUS && pwdata[0]
		&& !uf_w[0] && clk_en |=> !status_reg[0])
		else $error("status bit not cleared by write one");
	mask_write_a: assert property (wr_en && paddr == reload_timer_pkg::OFF_MASK && clk_en
		|=> mask_reg == $past(pwdata[N-1:0]))
		else $error("mask not stored");
	sticky_hold_a: assert property (status_reg[1] && clk_en
		&& !(wr_en && paddr == reload_timer_pkg::OFF_STATUS) |=> status_reg[1])
		else $error("status bit dropped without a clear");
	apb_err_a: assert property (pslverr |-> pready)
		else $error("error reply without ready");
	apb_idle_a: assert property (!psel && clk_en |=> !pready)
		else $error("ready without a request");
	irq_cov: cover property (irq);
endmodule // reload_timer_pair

// file: verif/pin_driver.sv
// partner model: trigger and event pins of both channels
// assumes core_clk from the bench; pins idle low between pulses
`timescale 1ns/10ps
module pin_driver
(
	// clock
	input wire logic core_clk,
	// pins
	output logic [1:0] ext_trig_in,
	output logic [1:0] ext_event_in
);
	initial
	begin
		ext_trig_in = 2'h0;
		ext_event_in = 2'h0;
	end

	// rising pin edges
	// held four clocks high and low so the two-flop sync never misses one
	task automatic pulse(input logic evt, input int ch, input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			ext_event_in[ch] <= evt;
			ext_trig_in[ch] <= !evt;
			repeat (4) @(posedge core_clk);
			ext_event_in[ch] <= 1'b0;
			ext_trig_in[ch] <= 1'b0;
			repeat (4) @(posedge core_clk);
		end
	endtask
endmodule // pin_driver

// file: verif/tb.sv
// testbench for the dual reload timer: apb tasks and directed tests
// assumes zero-wait apb slave and pin_driver as the pin partner
`timescale 1ns/10ps
module tb;
	localparam logic [7:0] ct0 = reload_timer_pkg::OFF_CTRL;
	localparam logic [7:0] rl0 = reload_timer_pkg::OFF_RELOAD;
	localparam logic [7:0] cn0 = reload_timer_pkg::OFF_COUNT;
	localparam logic [7:0] ct1 = ct0 + reload_timer_pkg::CH_STRIDE;
	localparam logic [7:0] rl1 = rl0 + reload_timer_pkg::CH_STRIDE;
	localparam logic [7:0] st = reload_timer_pkg::OFF_STATUS;
	localparam logic [7:0] mk = reload_timer_pkg::OFF_MASK;
	logic core_clk;
	logic resetn;
	logic clk_en;
	logic psel, penable, pwrite, pready, pslverr, irq, last_err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] ext_trig_in, ext_event_in, io_service_req;
	int mismatches, checks_done, cycles, n;
	int div[3] = '{2, 8, 32};

	reload_timer_pair reload_timer_pair_inst (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_trig_in(ext_trig_in),
		.ext_event_in(ext_event_in), .irq(irq), .io_service_req(io_service_req));
	pin_driver pin_driver_inst (.core_clk(core_clk), .ext_trig_in(ext_trig_in), .ext_event_in(ext_event_in));

	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic end_sim();
		if (mismatches == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// a hang ends the run as a mismatch
	always @(posedge core_clk)
	begin
		cycles = cycles + 1;
		if (cycles == 20000)
		begin
			mismatches++;
			end_sim();
		end
	end

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic poll(input logic [31:0] m);
		int t;
		t = 0;
		do
		begin
			apb(1'b0, st, 32'h0);
			t++;
		end
		while ((rd & m) == 0 && t < 200);
	endtask

	// counts clocks up to the next service pulse of a channel
	task automatic wait_io(input int ch);
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (io_service_req[ch] !== 1'b1 && n < 400);
	endtask

	initial
	begin
		resetn = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mismatches = 0;
		checks_done = 0;
		cycles = 0;
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		apb(1'b0, ct0, 32'h0); chk(rd, 32'h0);
		apb(1'b0, rl1, 32'h0); chk(rd, 32'hffff);
		apb(1'b1, 8'h30, 32'h1); chk({31'h0, last_err}, 32'h1);
		// one-shot at the fastest rate, interrupt masked then unmasked
		apb(1'b1, rl0, 32'h5);
		apb(1'b1, ct0, 32'h4);
		apb(1'b1, ct0, 32'h44);
		poll(32'h3); chk(rd, 32'h1);
		apb(1'b0, ct0, 32'h0); chk(rd, 32'h4);
		apb(1'b0, cn0, 32'h0); chk(rd, 32'hffff);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, mk, 32'h3);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, st, 32'h1);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		// reload period on channel 1 for each internal rate
		apb(1'b1, rl1, 32'h3);
		for (int s = 0; s < 3; s++)
		begin
			apb(1'b1, ct1, 32'h2c | s);
			apb(1'b1, ct1, 32'h6c | s);
			wait_io(1);
			wait_io(1); chk(n, 4 * div[s]);
			apb(1'b1, ct1, 32'h0);
		end
		apb(1'b0, cn0, 32'h0); chk(rd, 32'hffff);
		// external trigger pin in internal mode
		apb(1'b1, st, 32'h3);
		apb(1'b1, rl0, 32'hffff);
		apb(1'b1, ct0, 32'h14);
		apb(1'b0, ct0, 32'h0); chk(rd, 32'h14);
		pin_driver_inst.pulse(1'b0, 0, 1);
		apb(1'b0, ct0, 32'h0); chk(rd, 32'h94);
		// event count: pin trigger ignored, software trigger then two edges
		apb(1'b1, ct0, 32'h0);
		apb(1'b1, rl0, 32'h2);
		apb(1'b1, ct0, 32'h17);
		pin_driver_inst.pulse(1'b0, 0, 1);
		apb(1'b0, ct0, 32'h0); chk(rd, 32'h17);
		apb(1'b1, ct0, 32'h57);
		apb(1'b0, ct0, 32'h0); chk(rd, 32'h97);
		pin_driver_inst.pulse(1'b1, 0, 2);
		apb(1'b0, st, 32'h0); chk(rd, 32'h0);
		// an event edge while the clock enable is low is not seen
		clk_en <= 1'b0;
		pin_driver_inst.pulse(1'b1, 0, 1);
		clk_en <= 1'b1;
		apb(1'b0, cn0, 32'h0); chk(rd, 32'h0);
		apb(1'b0, st, 32'h0); chk(rd, 32'h0);
		pin_driver_inst.pulse(1'b1, 0, 1);
		poll(32'h1); chk(rd, 32'h1);
		apb(1'b0, ct0, 32'h0); chk(rd, 32'h17);
		end_sim();
	end
endmodule // tb
